/* File: common/emcfg_regs.svh */
// Offsets, field positions, reset values and timing counts of the
// memory interface configuration bank. Assumes a 32-bit APB map.
`ifndef EMCFG_REGS_SVH
`define EMCFG_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define WAIT_CFG_OFFSET     8'h04
`define SDRAM_CFG_OFFSET    8'h08
`define ASYNC_CFG_OFFSET    8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WAIT_POL_BIT        28
`define MAX_WAIT_LSB        0
`define SELF_REF_BIT        31
`define NARROW_BIT          14
`define CAS_LSB             9
`define KEY_BIT             8
`define BANK_LSB            4
`define COLSEL_LSB          0
`define EXT_WAIT_EN_BIT     30

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define MAX_WAIT_RST        8'h00
`define CAS_RST             3'h3
`define BANK_RST            3'h2
`define COLSEL_RST          3'h0
`define WAIT_UNIT_CYCLES    16
`define INIT_PULSE_CYCLES   1

`endif

/* File: common/emcfg_pkg.sv */
// Types shared by the configuration bank and the wait limiter.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package emcfg_pkg;

  // Configuration as seen by the sequencers
  typedef struct packed {
    logic       wait_polarity;
    logic [7:0] max_extended_wait;
    logic       extended_wait_enable;
    logic       self_refresh_request;
    logic       narrow_bus_select;
    logic [2:0] cas_latency_field;
    logic [2:0] bank_count;
    logic [2:0] column_width_select;
  } mem_cfg_t;

  // Decoded SDRAM geometry
  typedef struct packed {
    logic [1:0] cas_cycles;    // 0 when reserved code
    logic [3:0] column_bits;   // 0 when reserved code
    logic       cas_valid;
    logic       col_valid;
  } sdram_geom_t;

  // Wait limiter states
  typedef enum logic [1:0] {WT_IDLE, WT_WAIT, WT_DONE} wait_state_t;

endpackage
`default_nettype wire

/* File: hdl/wait_limiter.sv */
// Extended wait cycle limiter for one asynchronous access.
// Assumes wait_input already synchronised to pclk.
`default_nettype none
`include "emcfg_regs.svh"
module wait_limiter #(
  parameter int UNIT = `WAIT_UNIT_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       strobe_start,
  input  wire logic       wait_input,
  input  wire logic       enable,
  input  wire logic       polarity,
  input  wire logic [7:0] max_wait,
  output logic            stretch,
  output logic            go_hold
);
  // Counter is 13 bits: (255 + 1) * UNIT must stay below 8192
  if (UNIT < 1 || UNIT > 31)
  begin : g_bad_unit
    $error("UNIT out of range");
  end

  typedef struct packed {
    emcfg_pkg::wait_state_t st;
    logic [12:0]            cnt;
  } st_t;
  st_t s_r;
  st_t s_nxt;
  logic        asserted;
  logic [12:0] limit;

  // Wait asserted in the programmed sense
  assign asserted = enable && (wait_input == polarity);
  assign limit    = 13'((32'(max_wait) + 32'd1) * 32'(UNIT));

  // Count stretch cycles, restart on every strobe
  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      emcfg_pkg::WT_IDLE:
      begin
        s_nxt.cnt = 13'h0000;
      end
      emcfg_pkg::WT_WAIT:
      begin
        if (!asserted || s_r.cnt == limit - 13'h0001)
          s_nxt.st = emcfg_pkg::WT_DONE;
        else
          s_nxt.cnt = s_r.cnt + 13'h0001;
      end
      emcfg_pkg::WT_DONE:
      begin
        s_nxt.st = emcfg_pkg::WT_IDLE;
      end
      default:
      begin
        s_nxt.st = emcfg_pkg::WT_IDLE;
      end
    endcase
    if (strobe_start)
    begin
      s_nxt.st  = emcfg_pkg::WT_WAIT;
      s_nxt.cnt = 13'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '{st: emcfg_pkg::WT_IDLE, cnt: 13'h0000};
    else
      s_r <= s_nxt;
  end

  // Stretch only while asserted and below the limit
  assign stretch = (s_r.st == emcfg_pkg::WT_WAIT) && asserted;
  assign go_hold = (s_r.st == emcfg_pkg::WT_DONE);
endmodule // wait_limiter
`default_nettype wire

/* File: hdl/mem_cfg_bank.sv */
// Configuration bank of the external memory interface on APB.
// Assumes pclk shared with the sequencers; the wait pin is external.
`default_nettype none
`include "emcfg_regs.svh"
module mem_cfg_bank #(
  parameter bit HAS_WAIT_PIN = 1'b1
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   wait_input_pin,
  input  wire logic                   strobe_start,
  output logic                        stretch,
  output logic                        go_hold,
  output emcfg_pkg::mem_cfg_t         cfg,
  output emcfg_pkg::sdram_geom_t      geom,
  output logic                        init_start
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    emcfg_pkg::mem_cfg_t cfg;
    logic                init;
    logic                wsync0;
    logic                wsync1;
  } st_t;
  st_t  s_r;
  st_t  s_nxt;
  logic wr;
  logic rd;
  logic hit;

  // Latency decode, used for geometry and for nothing reserved
  function automatic logic [1:0] cas_cycles_f(input logic [2:0] c);
    case (c)
      3'h2:    cas_cycles_f = 2'h2;
      3'h3:    cas_cycles_f = 2'h3;
      default: cas_cycles_f = 2'h0;
    endcase
  endfunction

  // Column bits decode
  function automatic logic [3:0] col_bits_f(input logic [2:0] c);
    case (c)
      3'h0:    col_bits_f = 4'h8;
      3'h1:    col_bits_f = 4'h9;
      3'h2:    col_bits_f = 4'hA;
      default: col_bits_f = 4'h0;
    endcase
  endfunction

  // Address hit
  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == `WAIT_CFG_OFFSET) || (a == `SDRAM_CFG_OFFSET)
          || (a == `ASYNC_CFG_OFFSET);
  endfunction

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  // Zero wait states: every access ends in its first access cycle
  assign pready  = 1'b1;
  assign hit     = is_reg(paddr);
  assign pslverr = psel && penable && !hit;
  assign wr      = psel && penable && pwrite && hit;
  assign rd      = psel && !penable && !pwrite;

  // Next state of the bank
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.init   = 1'b0;
    s_nxt.wsync0 = wait_input_pin;
    s_nxt.wsync1 = s_r.wsync0;
    if (wr && paddr == `WAIT_CFG_OFFSET && HAS_WAIT_PIN)
    begin
      // Word register; byte lanes 3 and 0 carry the fields
      if (pstrb[3])
        s_nxt.cfg.wait_polarity = pwdata[`WAIT_POL_BIT];
      if (pstrb[0])
        s_nxt.cfg.max_extended_wait = pwdata[`MAX_WAIT_LSB +: 8];
    end
    if (wr && paddr == `ASYNC_CFG_OFFSET && pstrb[3])
      s_nxt.cfg.extended_wait_enable = pwdata[`EXT_WAIT_EN_BIT];
    if (wr && paddr == `SDRAM_CFG_OFFSET)
    begin
      if (pstrb[3])
        s_nxt.cfg.self_refresh_request = pwdata[`SELF_REF_BIT];
      if (pstrb[1])
      begin
        s_nxt.cfg.narrow_bus_select = pwdata[`NARROW_BIT];
        if (pwdata[`KEY_BIT])
          s_nxt.cfg.cas_latency_field = pwdata[`CAS_LSB +: 3];
      end
      if (pstrb[0])
        s_nxt.cfg.column_width_select = pwdata[`COLSEL_LSB +: 3];
      // Bank count reads fixed; only lower byte lanes start init
      s_nxt.init = |pstrb[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '{cfg: '{wait_polarity: 1'b0, max_extended_wait: `MAX_WAIT_RST,
                      extended_wait_enable: 1'b0, self_refresh_request: 1'b0,
                      narrow_bus_select: 1'b0, cas_latency_field: `CAS_RST,
                      bank_count: `BANK_RST, column_width_select: `COLSEL_RST},
               init: 1'b0, wsync0: 1'b0, wsync1: 1'b0};
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Read data, registered in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Reserved bits and the key bit always read zero
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (rd)
    begin
      rdata_nxt = 32'h00000000;
      if (paddr == `WAIT_CFG_OFFSET && HAS_WAIT_PIN)
      begin
        rdata_nxt[`WAIT_POL_BIT]       = s_r.cfg.wait_polarity;
        rdata_nxt[`MAX_WAIT_LSB +: 8]  = s_r.cfg.max_extended_wait;
      end
      else if (paddr == `SDRAM_CFG_OFFSET)
      begin
        rdata_nxt[`SELF_REF_BIT]       = s_r.cfg.self_refresh_request;
        rdata_nxt[`NARROW_BIT]         = s_r.cfg.narrow_bus_select;
        rdata_nxt[`CAS_LSB +: 3]       = s_r.cfg.cas_latency_field;
        rdata_nxt[`BANK_LSB +: 3]      = s_r.cfg.bank_count;
        rdata_nxt[`COLSEL_LSB +: 3]    = s_r.cfg.column_width_select;
      end
      else if (paddr == `ASYNC_CFG_OFFSET)
        rdata_nxt[`EXT_WAIT_EN_BIT]    = s_r.cfg.extended_wait_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_r <= 32'h00000000;
    else
      rdata_r <= rdata_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs to the sequencers
  // ----------------------------------------------------------------
  assign prdata          = rdata_r;
  assign cfg             = s_r.cfg;
  assign init_start      = s_r.init;
  assign geom.cas_cycles = cas_cycles_f(s_r.cfg.cas_latency_field);
  assign geom.column_bits = col_bits_f(s_r.cfg.column_width_select);
  assign geom.cas_valid  = |cas_cycles_f(s_r.cfg.cas_latency_field);
  assign geom.col_valid  = |col_bits_f(s_r.cfg.column_width_select);

  // Limiter; without a wait pin extended wait is never used
  wait_limiter #(
    .UNIT (`WAIT_UNIT_CYCLES)
  ) u_limiter (
    .pclk         (pclk),
    .presetn      (presetn),
    .strobe_start (strobe_start),
    .wait_input   (s_r.wsync1),
    .enable       (s_r.cfg.extended_wait_enable && HAS_WAIT_PIN),
    .polarity     (s_r.cfg.wait_polarity),
    .max_wait     (s_r.cfg.max_extended_wait),
    .stretch      (stretch),
    .go_hold      (go_hold)
  );
endmodule // mem_cfg_bank
`default_nettype wire

/* File: tb/mem_cfg_bank_assertions.sv */
// Port checker of the memory configuration bank.
// Assumes emcfg_pkg is compiled first; attached by bind.
`default_nettype none
module mem_cfg_bank_assertions (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic [31:0]            prdata,
  input wire logic                   wait_input_pin,
  input wire logic                   strobe_start,
  input wire logic                   stretch,
  input wire emcfg_pkg::mem_cfg_t    cfg,
  input wire emcfg_pkg::sdram_geom_t geom,
  input wire logic                   init_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        wr_sd;
  logic [11:0] cnt_r;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Taken write to the SDRAM register
  assign wr_sd = psel && penable && pwrite && paddr == 8'h08;
  // Stretch cycles since the strobe started
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt_r <= 12'h000;
    else if (strobe_start) cnt_r <= 12'h000;
    else if (stretch) cnt_r <= cnt_r + 12'h001;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_INIT_LOW: assert property (wr_sd && |pstrb[2:0] |=> init_start)
    else $error("no init after low byte write");
  AST_TOP_ONLY: assert property (wr_sd && pstrb == 4'h8 |=> !init_start
    && cfg.self_refresh_request == $past(pwdata[31]) && $stable(cfg.narrow_bus_select))
    else $error("top byte write wrong");
  AST_NARROW: assert property (wr_sd && pstrb[1] |=>
    cfg.narrow_bus_select == $past(pwdata[14])) else $error("narrow bit not taken");
  AST_CAS_KEY: assert property (wr_sd && pstrb[1] && !pwdata[8] |=>
    $stable(cfg.cas_latency_field)) else $error("latency written without key");
  AST_RSVD_ZERO: assert property (psel && penable && !pwrite && paddr == 8'h08
    |-> (prdata & 32'h7FFFB188) == 32'h00000000) else $error("reserved bits set");
  AST_CAS_MAP: assert property (geom.cas_cycles == (cfg.cas_latency_field == 3'h2 ?
    2'h2 : cfg.cas_latency_field == 3'h3 ? 2'h3 : 2'h0)) else $error("latency decode");
  AST_COL_MAP: assert property (geom.column_bits == (cfg.column_width_select == 3'h0 ?
    4'h8 : cfg.column_width_select == 3'h1 ? 4'h9 : cfg.column_width_select == 3'h2 ?
    4'hA : 4'h0)) else $error("column decode");
  AST_NO_EN: assert property (!cfg.extended_wait_enable |-> !stretch)
    else $error("stretch while disabled");
  AST_LIMIT: assert property (stretch |->
    {1'b0, cnt_r} < ({5'h00, cfg.max_extended_wait} + 13'h0001) * 13'h0010)
    else $error("wait too long");
  AST_POL: assert property (stretch |-> $past(wait_input_pin, 2) == cfg.wait_polarity)
    else $error("stretch at wrong level");
endmodule // mem_cfg_bank_assertions
bind mem_cfg_bank mem_cfg_bank_assertions mem_cfg_bank_assertions_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .wait_input_pin, .strobe_start,
  .stretch, .cfg, .geom, .init_start);
`default_nettype wire

/* File: tb/seq_model.sv */
// Model of the asynchronous sequencer: strobe starts and wait pin.
// Assumes the bench calls access() from its main process.
`default_nettype none
module seq_model (
  input  wire logic pclk,
  output logic      strobe_start,
  output logic      wait_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: no strobe, pin away from the waiting level
  initial
  begin
    strobe_start   = 1'b0;
    wait_input_pin = 1'b1;
  end
  // One access; pin set early so sync lag is out of the way
  task automatic access(input logic lvl, input int hold);
    @(posedge pclk);
    wait_input_pin <= lvl;
    repeat (3) @(posedge pclk);
    strobe_start <= 1'b1;
    @(posedge pclk);
    strobe_start <= 1'b0;
    repeat (hold - 1) @(posedge pclk);
    wait_input_pin <= !lvl;
    repeat (40) @(posedge pclk);
  endtask
endmodule // seq_model
`default_nettype wire

/* File: tb/tb.sv */
// Bench of the memory configuration bank: table of APB accesses,
// then wait limiter cases and a reset in mid-run.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s;
                  logic [31:0] rd; logic err; logic ini;} row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        wait_input_pin, strobe_start, stretch, go_hold, init_start;
  int          bad_count, checks, n_str, n_hold;
  row_t        rows [7] = '{
    '{8'h04, 32'hFFFFFFFF, 4'hF, 32'h100000FF, 1'b0, 1'b0},
    '{8'h08, 32'h00004502, 4'hF, 32'h00004422, 1'b0, 1'b1},
    '{8'h08, 32'hFFFFFEF1, 4'hF, 32'h80004421, 1'b0, 1'b1},
    '{8'h08, 32'h00000000, 4'h8, 32'h00004421, 1'b0, 1'b0},
    '{8'h08, 32'h00000000, 4'h2, 32'h00000421, 1'b0, 1'b1},
    '{8'h10, 32'h40000000, 4'hF, 32'h40000000, 1'b0, 1'b0},
    '{8'h20, 32'hFFFFFFFF, 4'hF, 32'h00000000, 1'b1, 1'b0}};
  // ----------------------------------------------------------------
  // Design, partner, clock
  // ----------------------------------------------------------------
  mem_cfg_bank mem_cfg_bank_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .wait_input_pin, .strobe_start, .stretch,
    .go_hold, .cfg(), .geom(), .init_start);
  seq_model seq_model_i (.pclk, .strobe_start, .wait_input_pin);
  always #2.5 pclk = !pclk;
  // Stretch cycles of the current access
  always @(posedge pclk)
    if (strobe_start) n_str <= 0;
    else if (stretch === 1'b1) n_str <= n_str + 1;
  // Hold hand-offs of the current access, one expected
  always @(posedge pclk)
    if (strobe_start) n_hold <= 0;
    else if (go_hold === 1'b1) n_hold <= n_hold + 1;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Setup, access until pready, then release
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e,
                     output logic ini);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    #1 ini = init_start;
  endtask
  task automatic wait_case(input logic lvl, input int hold, input int exp);
    seq_model_i.access(lvl, hold);
    chk(n_str, exp);
    chk(n_hold, 1);
  endtask
  task automatic finish_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic        e, ini;
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    n_str = 0;
    n_hold = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].a, 1'b1, rows[i].d, rows[i].s, r, e, ini);
      chk({e, ini}, {rows[i].err, rows[i].ini});
      apb(rows[i].a, 1'b0, 32'h0, 4'h0, r, e, ini);
      chk(r, rows[i].rd);
    end
    apb(8'h04, 1'b1, 32'h10000000, 4'hF, r, e, ini);
    wait_case(1'b1, 100, 16);
    apb(8'h04, 1'b1, 32'h00000001, 4'hF, r, e, ini);
    wait_case(1'b0, 100, 32);
    seq_model_i.access(1'b0, 5);
    chk(n_str >= 5 && n_str <= 7, 1);
    wait_case(1'b0, 100, 32);
    apb(8'h10, 1'b1, 32'h00000000, 4'hF, r, e, ini);
    wait_case(1'b0, 100, 0);
    // Reset in mid-run, then reset values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(8'h08, 1'b0, 32'h0, 4'h0, r, e, ini);
    chk(r, 32'h00000620);
    apb(8'h04, 1'b0, 32'h0, 4'h0, r, e, ini);
    chk(r, 32'h00000000);
    finish_test();
  end
  // Watchdog against a hang
  initial
  begin
    #50000;
    bad_count++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
